// ===== common/rph_defines.vh
// Behaviour
// RULE1 - Packet handling only while operating mode is 10 or 11.
// RULE2 - Format select 0 picks fixed length packets, 1 picks variable length.
// RULE3 - Fixed length is the length field, capped at queue size.
// RULE4 - Fixed packet: preamble, start pattern, optional address, data, optional CRC.
// RULE5 - Preamble, start pattern and CRC added on send, stripped on receive.
// RULE6 - Variable packet: preamble, start pattern, length, optional address, data, CRC. Code sends and checks the CRC only when check_enable_bit is set.
// RULE7 - Variable packet: first queued byte counts the remaining payload.
// RULE8 - Length byte above the length field discards the packet.
// RULE9 - Normal variable payload with length byte fits the queue.
// RULE10 - Variable format with length field 65 to 127 is extended.
// RULE11 - Preamble field 10 sends three bytes, 11 sends four.
// RULE12 - CRC runs when enabled; writing one clears the CRC status bit.
// RULE13 - Queue depth field 11 selects a 64 byte queue.
// RULE14 - Effective threshold is field plus one: 31 gives 32.
// RULE15 - Pin B receive map 11 shows count at or above threshold.
// RULE16 - Pin B receive mapping 00 shows the CRC pass event.
// RULE17 - Pin A transmit map 0 sends once count reaches threshold.
// RULE18 - With that mapping pin A shows count at or below threshold.
// RULE19 - Underrun ends sending early; writes to a full queue are lost.
// RULE20 - Received bytes reaching a full queue are lost.
// RULE21 - Host drains part per threshold event, leaving one byte.
// RULE22 - Host adds at most 64 minus threshold plus one bytes per refill.
// RULE23 - Pin B transmit map 1 shows send finished; host stays one bit.
// RULE24 - With CRC enabled a 16-bit payload checksum follows it.
// RULE25 - Address filter drops packets whose address byte misses.
`ifndef RPH_DEFINES_VH
`define RPH_DEFINES_VH

`define RPH_FIFO_W      8
`define RPH_FIFO_D      64
`define RPH_FIFO_AW     6
`define RPH_DEPTH_STEP  7'h10
`define RPH_EXT_MIN     7'h41
`define RPH_PREAMBLE    8'hAA
`define RPH_CRC_POLY    16'h1021
`define RPH_CRC_INIT    16'hFFFF
`define RPH_RXB_CRC     2'h0
`define RPH_RXB_FULL    2'h1
`define RPH_RXB_RSSI    2'h2
`define RPH_RXB_THR     2'h3
`define RPH_AF_OFF      2'h0
`define RPH_AF_OWN      2'h1
`define RPH_AF_ZERO     2'h2
`define RPH_BCAST_A     8'h00
`define RPH_BCAST_B     8'hFF

`endif

// ===== src/rph_packet_handler.v
`timescale 1ns/100ps
`default_nettype none
`include "rph_defines.vh"

// ****************************************
// Payload queue
// ****************************************
module rph_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             clr,
    input  wire             wr_valid,
    input  wire [WIDTH-1:0] wr_data,
    output wire             wr_ready,
    output wire             rd_valid,
    output wire [WIDTH-1:0] rd_data,
    input  wire             rd_ready,
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    wire            do_wr;
    wire            do_rd;

    assign wr_ready = (cnt_q != DEPTH);
    assign rd_valid = (cnt_q != {(AW+1){1'b0}});
    assign rd_data  = mem[rp_q];
    assign count    = cnt_q;
    assign do_wr    = wr_valid & wr_ready;
    assign do_rd    = rd_valid & rd_ready;

    always @(posedge clk) begin
        if (do_wr & ~clr) begin
            mem[wp_q] <= wr_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (clr) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_wr & ~do_rd) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (do_rd & ~do_wr) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // rph_fifo

// ****************************************
// Packet handler
// ****************************************
module rph_packet_handler (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [1:0]  operating_mode_field,
    input  wire        tx_mode,
    input  wire        packet_format_select,
    input  wire [6:0]  packet_length_field,
    input  wire [1:0]  preamble_length_field,
    input  wire [1:0]  start_pattern_length,
    input  wire [31:0] start_pattern,
    input  wire        check_enable_bit,
    input  wire        check_status_clear,
    output reg         check_status_bit,
    input  wire [1:0]  address_filter_select,
    input  wire [7:0]  own_node_address,
    input  wire [1:0]  queue_depth_field,
    input  wire [5:0]  queue_threshold_field,
    input  wire [1:0]  rx_pin_b_mapping,
    input  wire        tx_pin_a_mapping,
    input  wire        tx_pin_b_mapping,
    input  wire        rssi_event,
    input  wire        host_wr_valid,
    input  wire [7:0]  host_wr_data,
    output wire        host_wr_ready,
    output wire        host_rd_valid,
    output wire [7:0]  host_rd_data,
    input  wire        host_rd_ready,
    output reg  [7:0]  tx_byte_data,
    output reg         tx_byte_valid,
    input  wire        tx_byte_ready,
    input  wire        rx_start,
    input  wire [7:0]  rx_byte_data,
    input  wire        rx_byte_valid,
    output reg         data_lost,
    output reg         tx_stop,
    output reg         interrupt_pin_a,
    output reg         interrupt_pin_b
);
    localparam [2:0] R_IDLE = 3'h0;
    localparam [2:0] R_LEN  = 3'h1;
    localparam [2:0] R_PAY  = 3'h2;
    localparam [2:0] R_CRCH = 3'h3;
    localparam [2:0] R_CRCL = 3'h4;

    localparam [2:0] T_IDLE = 3'h0;
    localparam [2:0] T_PRE  = 3'h1;
    localparam [2:0] T_SYNC = 3'h2;
    localparam [2:0] T_PAY  = 3'h3;
    localparam [2:0] T_CRCH = 3'h4;
    localparam [2:0] T_CRCL = 3'h5;
    localparam [2:0] T_END  = 3'h6;

    function [15:0] crc_next;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] r;
        begin
            r = c;
            for (i = 7; i >= 0; i = i - 1) begin
                r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `RPH_CRC_POLY : 16'h0000);
            end
            crc_next = r;
        end
    endfunction

    function addr_ok;
        input [1:0] sel;
        input [7:0] a;
        input [7:0] own;
        begin
            case (sel)
                `RPH_AF_OFF:  addr_ok = 1'b1;
                `RPH_AF_OWN:  addr_ok = (a == own);
                `RPH_AF_ZERO: addr_ok = (a == own) | (a == `RPH_BCAST_A);
                default:      addr_ok = (a == own) | (a == `RPH_BCAST_A) | (a == `RPH_BCAST_B);
            endcase
        end
    endfunction

    // ****************************************
    // Configuration decode
    // ****************************************
    wire       pkt_on = operating_mode_field[1]; // RULE1
    wire [6:0] lim    = {1'b0, queue_depth_field, 4'h0} + `RPH_DEPTH_STEP; // RULE13
    wire [6:0] thr    = {1'b0, queue_threshold_field} + 7'h01; // RULE14
    wire [6:0] fixlen = (packet_length_field > lim) ? lim : packet_length_field; // RULE3
    wire       ext    = packet_format_select & (packet_length_field >= `RPH_EXT_MIN); // RULE10
    wire       tx_on  = pkt_on & tx_mode;
    wire       rx_on  = pkt_on & ~tx_mode;

    // ****************************************
    // Queue sharing between directions
    // ****************************************
    wire       f_wr_valid;
    wire [7:0] f_wr_data;
    wire       f_wr_ready;
    wire       f_rd_valid;
    wire [7:0] f_rd_data;
    wire       f_rd_ready;
    wire [6:0] f_cnt;
    wire       room;
    wire       rx_push;
    reg        rx_clr;
    wire       tx_pop;

    assign room          = f_wr_ready & (f_cnt < lim);
    assign f_wr_valid    = tx_mode ? host_wr_valid & pkt_on : rx_push;
    assign f_wr_data     = tx_mode ? host_wr_data : rx_byte_data;
    assign host_wr_ready = tx_on & room; // RULE1
    assign f_rd_ready    = tx_mode ? tx_pop : host_rd_ready;
    assign host_rd_valid = ~tx_mode & f_rd_valid;
    assign host_rd_data  = f_rd_data;

    rph_fifo #(
        .WIDTH (`RPH_FIFO_W),
        .DEPTH (`RPH_FIFO_D),
        .AW    (`RPH_FIFO_AW)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .clr      (rx_clr),
        .wr_valid (f_wr_valid & room),
        .wr_data  (f_wr_data),
        .wr_ready (f_wr_ready),
        .rd_valid (f_rd_valid),
        .rd_data  (f_rd_data),
        .rd_ready (f_rd_ready),
        .count    (f_cnt)
    );

    // ****************************************
    // Receive engine
    // ****************************************
    reg  [2:0]  rs_q;
    reg  [7:0]  rrem_q;
    reg  [15:0] rcrc_q;
    reg  [7:0]  rcrch_q;
    reg         rfirst_q;
    reg         crc_ok_q;
    reg         dat_rdy_q;
    reg         rx_ok_set;
    wire        rbyte    = rx_on & rx_byte_valid;
    wire        len_bad  = (rx_byte_data > {1'b0, packet_length_field}) |
                           (~ext & ({1'b0, rx_byte_data} + 9'h001 > {2'b00, lim})); // RULE8 RULE9
    wire        addr_bad = rfirst_q & ~addr_ok(address_filter_select, rx_byte_data,
                                               own_node_address); // RULE25
    wire        last_rd  = host_rd_valid & host_rd_ready & (f_cnt == 7'h01);

    assign rx_push = rbyte & (((rs_q == R_LEN) & ~len_bad) | ((rs_q == R_PAY) & ~addr_bad)); // RULE5

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_q      <= R_IDLE;
            rrem_q    <= 8'h00;
            rcrc_q    <= `RPH_CRC_INIT;
            rcrch_q   <= 8'h00;
            rfirst_q  <= 1'b0;
            crc_ok_q  <= 1'b0;
            dat_rdy_q <= 1'b0;
            rx_clr    <= 1'b0;
            rx_ok_set <= 1'b0;
        end else begin
            rx_clr    <= 1'b0;
            rx_ok_set <= 1'b0;
            if (last_rd) begin
                crc_ok_q  <= 1'b0;
                dat_rdy_q <= 1'b0;
            end
            if (!rx_on) begin
                rs_q <= R_IDLE;
            end else if (rx_start) begin
                crc_ok_q  <= 1'b0;
                dat_rdy_q <= 1'b0;
                rcrc_q    <= `RPH_CRC_INIT;
                rfirst_q  <= 1'b1;
                rrem_q    <= {1'b0, fixlen};
                rs_q      <= packet_format_select ? R_LEN : R_PAY; // RULE2
            end else if (rbyte) begin
                case (rs_q)
                    R_LEN: begin
                        if (len_bad) begin
                            rs_q <= R_IDLE;
                        end else begin
                            rcrc_q <= crc_next(rcrc_q, rx_byte_data); // RULE7
                            rrem_q <= rx_byte_data;
                            if (rx_byte_data == 8'h00) begin
                                rs_q      <= check_enable_bit ? R_CRCH : R_IDLE;
                                dat_rdy_q <= ~check_enable_bit;
                            end else begin
                                rs_q <= R_PAY;
                            end
                        end
                    end
                    R_PAY: begin
                        rfirst_q <= 1'b0;
                        if (addr_bad) begin
                            rx_clr <= 1'b1;
                            rs_q   <= R_IDLE;
                        end else begin
                            rcrc_q <= crc_next(rcrc_q, rx_byte_data);
                            rrem_q <= rrem_q - 8'h01;
                            if (rrem_q == 8'h01) begin
                                rs_q      <= check_enable_bit ? R_CRCH : R_IDLE; // RULE12
                                dat_rdy_q <= ~check_enable_bit;
                            end
                        end
                    end
                    R_CRCH: begin
                        rcrch_q <= rx_byte_data;
                        rs_q    <= R_CRCL;
                    end
                    R_CRCL: begin
                        rs_q <= R_IDLE;
                        if ({rcrch_q, rx_byte_data} == rcrc_q) begin
                            crc_ok_q  <= 1'b1;
                            dat_rdy_q <= 1'b1;
                            rx_ok_set <= 1'b1;
                        end else begin
                            rx_clr <= 1'b1;
                        end
                    end
                    default: begin
                        rs_q <= R_IDLE;
                    end
                endcase
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            check_status_bit <= 1'b0;
        end else if (rx_ok_set) begin
            check_status_bit <= 1'b1;
        end else if (check_status_clear) begin
            check_status_bit <= 1'b0; // RULE12
        end
    end

    // ****************************************
    // Transmit engine
    // ****************************************
    reg  [2:0]  ts_q;
    reg  [1:0]  tk_q;
    reg  [7:0]  trem_q;
    reg  [15:0] tcrc_q;
    reg         tfirst_q;
    reg         tunder_q;
    wire        adv   = ~tx_byte_valid | tx_byte_ready;
    wire        go    = tx_pin_a_mapping ? (f_cnt != 7'h00) : (f_cnt >= thr); // RULE17
    wire        tlast = (tfirst_q & packet_format_select) ? (f_rd_data == 8'h00)
                                                          : (trem_q == 8'h01);
    wire [15:0] tcrc_n = crc_next(tcrc_q, f_rd_data);

    assign tx_pop = tx_on & (ts_q == T_PAY) & adv & f_rd_valid;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_q          <= T_IDLE;
            tk_q          <= 2'h0;
            trem_q        <= 8'h00;
            tcrc_q        <= `RPH_CRC_INIT;
            tfirst_q      <= 1'b0;
            tunder_q      <= 1'b0;
            tx_byte_data  <= 8'h00;
            tx_byte_valid <= 1'b0;
            tx_stop       <= 1'b0;
        end else begin
            tunder_q <= 1'b0;
            if (adv) begin
                tx_byte_valid <= 1'b0;
            end
            if (!tx_on) begin
                ts_q          <= T_IDLE;
                tx_stop       <= 1'b0;
                tx_byte_valid <= 1'b0;
            end else if (adv) begin
                case (ts_q)
                    T_IDLE: begin
                        if (go & ~tx_stop) begin
                            ts_q   <= T_PRE;
                            tk_q   <= preamble_length_field; // RULE11
                            tcrc_q <= `RPH_CRC_INIT;
                        end
                    end
                    T_PRE: begin
                        tx_byte_data  <= `RPH_PREAMBLE; // RULE4 RULE6
                        tx_byte_valid <= 1'b1;
                        tk_q          <= tk_q - 2'h1;
                        if (tk_q == 2'h0) begin
                            ts_q <= T_SYNC;
                            tk_q <= start_pattern_length;
                        end
                    end
                    T_SYNC: begin
                        tx_byte_data  <= start_pattern[{tk_q, 3'h0} +: 8];
                        tx_byte_valid <= 1'b1;
                        tk_q          <= tk_q - 2'h1;
                        if (tk_q == 2'h0) begin
                            ts_q     <= T_PAY;
                            tfirst_q <= 1'b1;
                            trem_q   <= {1'b0, fixlen};
                        end
                    end
                    T_PAY: begin
                        if (!f_rd_valid) begin
                            tunder_q <= 1'b1;
                            ts_q     <= T_END; // RULE19
                        end else begin
                            tx_byte_data  <= f_rd_data;
                            tx_byte_valid <= 1'b1;
                            tcrc_q        <= tcrc_n;
                            tfirst_q      <= 1'b0;
                            if (tfirst_q & packet_format_select) begin
                                trem_q <= f_rd_data; // RULE7
                            end else begin
                                trem_q <= trem_q - 8'h01;
                            end
                            if (tlast) begin
                                ts_q <= check_enable_bit ? T_CRCH : T_END;
                            end
                        end
                    end
                    T_CRCH: begin
                        tx_byte_data  <= tcrc_q[15:8]; // RULE24
                        tx_byte_valid <= 1'b1;
                        ts_q          <= T_CRCL;
                    end
                    T_CRCL: begin
                        tx_byte_data  <= tcrc_q[7:0];
                        tx_byte_valid <= 1'b1;
                        ts_q          <= T_END;
                    end
                    T_END: begin
                        tx_stop <= 1'b1; // RULE23
                        ts_q    <= T_IDLE;
                    end
                    default: begin
                        ts_q <= T_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Loss report and interrupt pins
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_lost <= 1'b0;
        end else begin
            data_lost <= tunder_q | (tx_mode & host_wr_valid & ~room) |
                         (rx_push & ~room); // RULE19 RULE20
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_pin_a <= 1'b0;
            interrupt_pin_b <= 1'b0;
        end else if (!pkt_on) begin
            interrupt_pin_a <= 1'b0;
            interrupt_pin_b <= 1'b0;
        end else if (tx_mode) begin
            interrupt_pin_a <= tx_pin_a_mapping ? (f_cnt != 7'h00) : (f_cnt <= thr); // RULE18
            interrupt_pin_b <= tx_pin_b_mapping ? tx_stop : (f_cnt >= lim);
        end else begin
            interrupt_pin_a <= dat_rdy_q;
            case (rx_pin_b_mapping)
                `RPH_RXB_CRC:  interrupt_pin_b <= crc_ok_q; // RULE16
                `RPH_RXB_FULL: interrupt_pin_b <= (f_cnt >= lim);
                `RPH_RXB_RSSI: interrupt_pin_b <= rssi_event;
                default:       interrupt_pin_b <= (f_cnt >= thr); // RULE15
            endcase
        end
    end
endmodule // rph_packet_handler
`default_nettype wire

// ===== testbench/rph_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module rph_props (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] operating_mode_field,
    input wire logic       tx_mode,
    input wire logic       check_enable_bit,
    input wire logic       check_status_clear,
    input wire logic       check_status_bit,
    input wire logic       tx_pin_b_mapping,
    input wire logic       host_wr_valid,
    input wire logic       host_wr_ready,
    input wire logic [7:0] tx_byte_data,
    input wire logic       tx_byte_valid,
    input wire logic       tx_byte_ready,
    input wire logic       data_lost,
    input wire logic       tx_stop,
    input wire logic       interrupt_pin_a,
    input wire logic       interrupt_pin_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire on_w = operating_mode_field[1] & tx_mode;
    wr_lost_a: assert property (host_wr_valid && !host_wr_ready && on_w |=> data_lost)
        else $error("no loss pulse");
    mode_wr_a: assert property (!operating_mode_field[1] |-> !host_wr_ready)
        else $error("ready off mode");
    pins_idle_a: assert property (!operating_mode_field[1] && !$past(operating_mode_field[1])
        |-> !interrupt_pin_a && !interrupt_pin_b)
        else $error("pin off mode");
    tx_hold_a: assert property (tx_byte_valid && !tx_byte_ready && on_w
        |=> tx_byte_valid && $stable(tx_byte_data))
        else $error("byte dropped");
    tx_off_a: assert property (!tx_mode && !$past(tx_mode) |-> !tx_byte_valid && !tx_stop)
        else $error("send while off");
    stop_hold_a: assert property (tx_stop && on_w |=> tx_stop)
        else $error("stop fell");
    stop_pin_a: assert property ((on_w && tx_pin_b_mapping && tx_stop) [*2] |-> interrupt_pin_b)
        else $error("no stop pin");
    crc_clr_a: assert property (check_status_clear && !check_enable_bit |=> !check_status_bit)
        else $error("not cleared");
endmodule // rph_props

bind rph_packet_handler rph_props i_rph_props (.*);
`default_nettype wire

// ===== testbench/rph_mod_sink.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Modulator byte sink
// ****
module rph_mod_sink (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       stall,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte_data,
    input  wire logic       tx_byte_valid,
    output logic            tx_byte_ready
);
    logic [7:0] got [$];
    // Slow mode takes a byte every other cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_ready <= 1'h0;
        end else begin
            if (tx_byte_valid && tx_byte_ready) got.push_back(tx_byte_data);
            tx_byte_ready <= !stall && (!slow || !tx_byte_ready);
        end
    end
endmodule // rph_mod_sink
`default_nettype wire

// ===== testbench/rph_packet_handler_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rph_defines.vh"
module rph_packet_handler_tb;
    logic clk = 1'h0, rst_n = 1'h0, tx_mode = 1'h0, packet_format_select = 1'h0;
    logic check_enable_bit = 1'h0, check_status_clear = 1'h0, tx_pin_a_mapping = 1'h0;
    logic tx_pin_b_mapping = 1'h1, rssi_event = 1'h0, host_wr_valid = 1'h0, host_rd_ready = 1'h0;
    logic rx_start = 1'h0, rx_byte_valid = 1'h0, stall = 1'h0, slow = 1'h0;
    logic [1:0] operating_mode_field = 2'h0, preamble_length_field = 2'h0, start_pattern_length = 2'h0;
    logic [1:0] address_filter_select = 2'h0, queue_depth_field = 2'h3, rx_pin_b_mapping = 2'h0;
    logic [6:0] packet_length_field = 7'h00;
    logic [5:0] queue_threshold_field = 6'h00;
    logic [31:0] start_pattern = 32'h1234_5678;
    logic [7:0] own_node_address = 8'h00, host_wr_data = 8'h00, rx_byte_data = 8'h00, b;
    wire check_status_bit, host_wr_ready, host_rd_valid, tx_byte_valid, tx_byte_ready;
    wire data_lost, tx_stop, interrupt_pin_a, interrupt_pin_b;
    wire [7:0] host_rd_data, tx_byte_data;
    int mismatches = 0, cmp_count = 0, i, j;
    logic [7:0] exp_q [$];
    logic [7:0] rx_pk [3] = '{8'h02, 8'h5A, 8'hC3};
    typedef struct packed {logic f; logic [1:0] p, s; logic [3:0] n; logic w; logic [4:0] t;} rph_row_t;
    rph_row_t rows [3] = '{'{1'h0, 2'h2, 2'h1, 4'h3, 1'h0, 5'h08},
                           '{1'h0, 2'h3, 2'h3, 4'h2, 1'h1, 5'h0A},
                           '{1'h1, 2'h2, 2'h0, 4'h4, 1'h1, 5'h08}};

    rph_packet_handler i_rph_packet_handler (.*);
    rph_mod_sink i_rph_mod_sink (.*);
    always #4 clk = ~clk;

    // ****
    // Helpers
    // ****
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic fail;
        mismatches++;
        results();
    endtask
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        logic ok = 1'h0;
        @(posedge clk) host_wr_valid <= 1'h1;
        host_wr_data <= d;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge clk) ok = (host_wr_ready === 1'h1);
            @(posedge clk);
        end
        host_wr_valid <= 1'h0;
        if (!ok) fail();
    endtask
    task automatic rd(output logic [7:0] d);
        logic ok = 1'h0;
        @(posedge clk) host_rd_ready <= 1'h1;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge clk) ok = (host_rd_valid === 1'h1);
            d = host_rd_data;
            @(posedge clk);
        end
        host_rd_ready <= 1'h0;
        if (!ok) fail();
    endtask
    task automatic rxb(input logic [7:0] d);
        @(posedge clk) rx_byte_valid <= 1'h1;
        rx_byte_data <= d;
        @(posedge clk) rx_byte_valid <= 1'h0;
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        @(negedge clk) cmp8("tx_stop_rst", 1'h0, tx_stop);
        cmp8("lost_rst", 1'h0, data_lost);
        @(posedge clk) rst_n <= 1'h1;
        @(posedge clk) tx_mode <= 1'h1;
        @(negedge clk) cmp8("wr_ready_idle", 1'h0, host_wr_ready);
        @(posedge clk) operating_mode_field <= 2'h2;
        tx_mode <= 1'h0;
        for (i = 0; i < 3; i++) begin
            @(posedge clk) packet_format_select <= rows[i].f;
            preamble_length_field <= rows[i].p;
            start_pattern_length <= rows[i].s;
            packet_length_field <= {3'h0, rows[i].n};
            slow <= rows[i].w;
            tx_mode <= 1'h1;
            exp_q.delete();
            repeat (rows[i].p + 1) exp_q.push_back(`RPH_PREAMBLE);
            for (j = rows[i].s; j >= 0; j--) exp_q.push_back(start_pattern[8*j+:8]);
            for (j = 0; j < rows[i].n; j++) begin
                b = (rows[i].f && j == 0) ? {4'h0, rows[i].n - 4'h1} : 8'h30 + 8'(j);
                exp_q.push_back(b);
                wr(b);
            end
            for (j = 0; j < 500 && tx_stop !== 1'h1; j++) @(negedge clk);
            if (tx_stop !== 1'h1) fail();
            cmp8("tx_count", {3'h0, rows[i].t}, 8'(i_rph_mod_sink.got.size()));
            for (j = 0; j < exp_q.size(); j++) cmp8("tx_byte", exp_q[j], i_rph_mod_sink.got[j]);
            repeat (2) @(negedge clk);
            cmp8("pin_b_stop", 1'h1, interrupt_pin_b);
            @(posedge clk) tx_mode <= 1'h0;
            repeat (2) @(posedge clk);
            i_rph_mod_sink.got.delete();
            $display("tx row %0d done", i);
        end
        @(posedge clk) queue_depth_field <= 2'h0;
        stall <= 1'h1;
        tx_mode <= 1'h1;
        tx_pin_b_mapping <= 1'h0;
        packet_format_select <= 1'h0;
        packet_length_field <= 7'h10;
        repeat (2) @(negedge clk);
        cmp8("pin_a_low", 1'h1, interrupt_pin_a);
        cmp8("tx_wait", 1'h0, tx_byte_valid);
        for (j = 0; j < 16; j++) wr(8'(j));
        repeat (2) @(negedge clk);
        cmp8("pin_a_high", 1'h0, interrupt_pin_a);
        cmp8("tx_start", 1'h1, tx_byte_valid);
        @(posedge clk) host_wr_valid <= 1'h1;
        @(negedge clk) cmp8("wr_ready_full", 1'h0, host_wr_ready);
        @(posedge clk) host_wr_valid <= 1'h0;
        @(negedge clk) cmp8("data_lost", 1'h1, data_lost);
        $display("full test done");
        @(posedge clk) rst_n <= 1'h0;
        tx_mode <= 1'h0;
        stall <= 1'h0;
        queue_depth_field <= 2'h3;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        operating_mode_field <= 2'h3;
        packet_format_select <= 1'h1;
        packet_length_field <= 7'h04;
        rx_pin_b_mapping <= 2'h3;
        @(posedge clk) check_status_clear <= 1'h1;
        @(posedge clk) check_status_clear <= 1'h0;
        @(negedge clk) cmp8("crc_stat", 1'h0, check_status_bit);
        @(posedge clk) rx_start <= 1'h1;
        @(posedge clk) rx_start <= 1'h0;
        for (j = 0; j < 6; j++) rxb(8'h05);
        repeat (4) @(negedge clk);
        cmp8("rx_drop", 1'h0, host_rd_valid);
        @(posedge clk) rx_start <= 1'h1;
        @(posedge clk) rx_start <= 1'h0;
        for (j = 0; j < 3; j++) rxb(rx_pk[j]);
        repeat (3) @(negedge clk);
        cmp8("pin_a_rdy", 1'h1, interrupt_pin_a);
        cmp8("pin_b_thr", 1'h1, interrupt_pin_b);
        for (j = 0; j < 3; j++) begin
            rd(b);
            cmp8("rx_byte", rx_pk[j], b);
        end
        $display("rx test done");
        results();
    end
endmodule // rph_packet_handler_tb
`default_nettype wire
